/* verilog/aocs_pkg.sv */
// package: selector codes, register map, timing constants and carriers
package aocs_pkg;

   // selector codes, in table order
   localparam logic [4:0] SEL_NONE         = 5'h00;
   localparam logic [4:0] SEL_FD_REF_MATCH = 5'h01;
   localparam logic [4:0] SEL_FD_REF_SETPT = 5'h02;
   localparam logic [4:0] SEL_FD_BAND      = 5'h03;
   localparam logic [4:0] SEL_FD_LEVEL     = 5'h04;
   localparam logic [4:0] SEL_FD_LEVEL_INV = 5'h05;
   localparam logic [4:0] SEL_LOAD_WARN    = 5'h06;
   localparam logic [4:0] SEL_DRIVE_OVL    = 5'h07;
   localparam logic [4:0] SEL_STALL        = 5'h08;
   localparam logic [4:0] SEL_DC_HIGH      = 5'h09;
   localparam logic [4:0] SEL_DC_LOW       = 5'h0a;
   localparam logic [4:0] SEL_HEATSINK     = 5'h0b;
   localparam logic [4:0] SEL_LOST_REF     = 5'h0c;
   localparam logic [4:0] SEL_RUN          = 5'h0d;
   localparam logic [4:0] SEL_STOP         = 5'h0e;
   localparam logic [4:0] SEL_STEADY       = 5'h0f;
   localparam logic [4:0] SEL_DRIVE_LINE   = 5'h10;
   localparam logic [4:0] SEL_UTIL_LINE    = 5'h11;
   localparam logic [4:0] SEL_RESYNC       = 5'h12;
   localparam logic [4:0] SEL_READY        = 5'h13;
   localparam logic [4:0] SEL_MULTI_MOTOR  = 5'h14;

   // register byte offsets
   localparam logic [7:0] OFS_SEL0      = 8'h00;
   localparam logic [7:0] OFS_SEL1      = 8'h04;
   localparam logic [7:0] OFS_SEL2      = 8'h08;
   localparam logic [7:0] OFS_SEL3      = 8'h0c;
   localparam logic [7:0] OFS_FDT_FREQ  = 8'h10;
   localparam logic [7:0] OFS_FDT_BW    = 8'h14;
   localparam logic [7:0] OFS_LW_LEVEL  = 8'h18;
   localparam logic [7:0] OFS_LW_TIME   = 8'h1c;
   localparam logic [7:0] OFS_APP_MODE  = 8'h20;
   localparam logic [7:0] OFS_STATUS    = 8'h24;

   // reset values
   localparam logic [4:0]  RST_SEL      = 5'h00;
   localparam logic [15:0] RST_WORD     = 16'h0000;
   localparam logic [3:0]  RST_APP_MODE = 4'h0;
   localparam logic [3:0]  APP_MMC      = 4'h1;   // multi-motor mode code

   // field positions in status register
   localparam int ST_CONTACT_LSB = 0;
   localparam int ST_TRIP_BIT    = 8;
   localparam int ST_OVL_BIT     = 9;

   // timing
   localparam int CLK_HZ          = 100_000_000;
   localparam int OVL_WARN_S      = 60;
   localparam int OVL_TRIP_S      = 60;   // further minute
   localparam int INTERLOCK_MS    = 500;
   localparam longint OVL_WARN_CYC  = longint'(OVL_WARN_S) * CLK_HZ;
   localparam longint OVL_TRIP_CYC  = longint'(OVL_TRIP_S) * CLK_HZ;
   localparam longint INTERLOCK_CYC = longint'(INTERLOCK_MS) * (CLK_HZ / 1000);
   localparam int LW_TIME_UNIT_CYC  = CLK_HZ / 10;   // load-warning time in 0.1 s
   localparam int OVL_PCT           = 110;

   // drive quantities carrier
   typedef struct packed {
      logic [15:0] ref_freq;
      logic [15:0] out_freq;
      logic [15:0] out_current;
      logic [15:0] rated_current;
   } aocs_meas_type;

   // drive status flags carrier
   typedef struct packed {
      logic accel;
      logic decel;
      logic stall;
      logic dc_over;
      logic dc_under;
      logic heatsink_hot;
      logic ref_lost;
      logic running;
      logic resync;
      logic ready;
      logic exchange;
   } aocs_flags_type;

endpackage : aocs_pkg

/* verilog/aocs_top.sv */
// auxiliary contact output condition selector with axi4-lite registers
`timescale 1ns/1ps
module aocs_top #(
   parameter longint OVL_WARN_CYCLES  = aocs_pkg::OVL_WARN_CYC,
   parameter longint OVL_TRIP_CYCLES  = aocs_pkg::OVL_TRIP_CYC,
   parameter longint INTERLOCK_CYCLES = aocs_pkg::INTERLOCK_CYC,
   parameter int     LW_UNIT_CYCLES   = aocs_pkg::LW_TIME_UNIT_CYC
) (
   input  wire logic                     clk_in,
   input  wire logic                     rst_n_in,
   // axi4-lite slave
   input  wire logic [7:0]               s_axi_awaddr_in,
   input  wire logic                     s_axi_awvalid_in,
   output logic                          s_axi_awready_out,
   input  wire logic [31:0]              s_axi_wdata_in,
   input  wire logic [3:0]               s_axi_wstrb_in,
   input  wire logic                     s_axi_wvalid_in,
   output logic                          s_axi_wready_out,
   output logic [1:0]                    s_axi_bresp_out,
   output logic                          s_axi_bvalid_out,
   input  wire logic                     s_axi_bready_in,
   input  wire logic [7:0]               s_axi_araddr_in,
   input  wire logic                     s_axi_arvalid_in,
   output logic                          s_axi_arready_out,
   output logic [31:0]                   s_axi_rdata_out,
   output logic [1:0]                    s_axi_rresp_out,
   output logic                          s_axi_rvalid_out,
   input  wire logic                     s_axi_rready_in,
   // drive quantities and status, same clock domain
   input  wire aocs_pkg::aocs_meas_type  meas_in,
   input  wire aocs_pkg::aocs_flags_type flags_in,
   // contacts and trip
   output logic [3:0]                    aux_contact_out,
   output logic                          overload_trip_out,
   output logic                          output_cutoff_out
);

   ////////////////////////////////////////////////////////////////////////
   // registers
   logic [4:0]  sel_r [4];          // contact selectors
   logic [15:0] fdt_freq_r;         // detection setpoint
   logic [15:0] fdt_bw_r;           // detection bandwidth
   logic [15:0] load_warning_level; // current warning level
   logic [15:0] load_warning_time;  // 0.1 s units
   logic [3:0]  application_mode_setting;
   logic        wr_pend_r;          // write address taken
   logic        wd_pend_r;          // write data taken
   logic [7:0]  waddr_r;
   logic [31:0] wdata_r;
   logic [3:0]  wstrb_r;

   // helper: absolute difference
   function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
      absdiff = (a >= b) ? (a - b) : (b - a);
   endfunction

   // helper: byte-lane merge of 16-bit field
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // frequency comparators, all every cycle
   wire [15:0] half_bw    = {1'b0, fdt_bw_r[15:1]};
   wire        fd_ref     = absdiff(meas_in.ref_freq, meas_in.out_freq) <= half_bw;
   wire        fd_setpt   = absdiff(meas_in.out_freq, fdt_freq_r) <= half_bw;
   wire        fd_both    = fd_ref && fd_setpt;
   wire [16:0] lo_edge    = {1'b0, fdt_freq_r} - {1'b0, half_bw};
   wire        lvl_acc    = meas_in.out_freq >= fdt_freq_r;
   wire        lvl_dec    = lo_edge[16] || ({1'b0, meas_in.out_freq} > lo_edge);
   logic       lvl_r;                                                                   // hysteresis state

   ////////////////////////////////////////////////////////////////////////
   // load and overload timing
   wire        lw_above  = meas_in.out_current >= load_warning_level;
   wire [31:0] ovl_lim   = 32'(meas_in.rated_current) * 32'(aocs_pkg::OVL_PCT);
   wire        ovl_above = (32'(meas_in.out_current) * 32'd100) > ovl_lim;
   logic [39:0] lw_cnt_r;
   logic [39:0] ovl_cnt_r;
   logic        lw_hit_r;
   logic        ovl_warn_r;
   wire [39:0]  lw_need = 40'(load_warning_time) * 40'(LW_UNIT_CYCLES);

   ////////////////////////////////////////////////////////////////////////
   // line exchange interlock
   typedef enum logic [2:0] {
      LX_DRIVE = 3'b001,    // drive line closed
      LX_GAP   = 3'b010,    // both open, waiting
      LX_UTIL  = 3'b100     // utility line closed
   } aocs_lx_type;
   aocs_lx_type lx_r;
   logic        lx_target_r;   // 1 = utility side wanted after gap
   logic [31:0] gap_cnt_r;
   wire         drive_line_select   = (lx_r == LX_DRIVE);
   wire         utility_line_select = (lx_r == LX_UTIL);

   ////////////////////////////////////////////////////////////////////////
   // condition vector indexed by selector code
   logic [31:0] cond;
   always_comb begin
      cond = 32'h0;
      cond[aocs_pkg::SEL_FD_REF_MATCH] = fd_ref;
      cond[aocs_pkg::SEL_FD_REF_SETPT] = fd_both;
      cond[aocs_pkg::SEL_FD_BAND]      = fd_setpt;
      cond[aocs_pkg::SEL_FD_LEVEL]     = lvl_r;
      cond[aocs_pkg::SEL_FD_LEVEL_INV] = ~lvl_r;
      cond[aocs_pkg::SEL_LOAD_WARN]    = lw_hit_r;
      cond[aocs_pkg::SEL_DRIVE_OVL]    = ovl_warn_r;
      cond[aocs_pkg::SEL_STALL]        = flags_in.stall;
      cond[aocs_pkg::SEL_DC_HIGH]      = flags_in.dc_over;
      cond[aocs_pkg::SEL_DC_LOW]       = flags_in.dc_under;
      cond[aocs_pkg::SEL_HEATSINK]     = flags_in.heatsink_hot;
      cond[aocs_pkg::SEL_LOST_REF]     = flags_in.ref_lost;
      cond[aocs_pkg::SEL_RUN]          = flags_in.running;
      cond[aocs_pkg::SEL_STOP]         = ~flags_in.running;
      cond[aocs_pkg::SEL_STEADY]       = flags_in.running & ~flags_in.accel
                                         & ~flags_in.decel;
      cond[aocs_pkg::SEL_DRIVE_LINE]   = drive_line_select;
      cond[aocs_pkg::SEL_UTIL_LINE]    = utility_line_select;
      cond[aocs_pkg::SEL_RESYNC]       = flags_in.resync;
      cond[aocs_pkg::SEL_READY]        = flags_in.ready;
      cond[aocs_pkg::SEL_MULTI_MOTOR]  = 1'b0;                                 // never set, so multi-motor mode holds every contact open
   end

   // effective selector: multi-motor mode overrides
   wire mmc_mode = (application_mode_setting == aocs_pkg::APP_MMC);

   ////////////////////////////////////////////////////////////////////////
   // contact outputs, one per selector
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_contact
         wire [4:0] eff_sel = mmc_mode ? aocs_pkg::SEL_MULTI_MOTOR : sel_r[g];
         wire       close   = (eff_sel != aocs_pkg::SEL_NONE) && cond[eff_sel];
         // registered contact
         always_ff @(posedge clk_in) begin
            if (!rst_n_in) begin
               aux_contact_out[g] <= 1'b0;
            end else begin
               aux_contact_out[g] <= close;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // level detect hysteresis: decel uses lower edge only, else upper edge sets
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         lvl_r <= 1'b0;
      end else if (flags_in.decel) begin
         lvl_r <= lvl_r & lvl_dec;                 // stays while above low edge
      end else begin
         lvl_r <= lvl_acc | (lvl_r & lvl_dec);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // load warning timer
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         lw_cnt_r <= 40'h0;
         lw_hit_r <= 1'b0;
      end else if (!lw_above) begin
         lw_cnt_r <= 40'h0;
         lw_hit_r <= 1'b0;
      end else begin
         if (lw_cnt_r < lw_need) begin
            lw_cnt_r <= lw_cnt_r + 40'h1;
         end
         lw_hit_r <= (lw_cnt_r >= lw_need);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // overload timer, warn then trip; trip latches until reset
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         ovl_cnt_r         <= 40'h0;
         ovl_warn_r        <= 1'b0;
         overload_trip_out <= 1'b0;
         output_cutoff_out <= 1'b0;
      end else begin
         if (!ovl_above) begin
            ovl_cnt_r  <= 40'h0;
            ovl_warn_r <= 1'b0;
         end else begin
            if (ovl_cnt_r < 40'(OVL_WARN_CYCLES + OVL_TRIP_CYCLES)) begin
               ovl_cnt_r <= ovl_cnt_r + 40'h1;
            end
            ovl_warn_r <= (ovl_cnt_r >= 40'(OVL_WARN_CYCLES));
            if (ovl_cnt_r >= 40'(OVL_WARN_CYCLES + OVL_TRIP_CYCLES)) begin
               overload_trip_out <= 1'b1;
               output_cutoff_out <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // line exchange: break before make with fixed gap
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         lx_r        <= LX_DRIVE;
         lx_target_r <= 1'b0;
         gap_cnt_r   <= 32'h0;
      end else begin
         case (lx_r)
            LX_DRIVE: begin
               if (flags_in.exchange) begin
                  lx_r        <= LX_GAP;   // open first
                  lx_target_r <= 1'b1;
                  gap_cnt_r   <= 32'h0;
               end
            end
            LX_UTIL: begin
               if (!flags_in.exchange) begin
                  lx_r        <= LX_GAP;
                  lx_target_r <= 1'b0;
                  gap_cnt_r   <= 32'h0;
               end
            end
            LX_GAP: begin
               if (gap_cnt_r >= 32'(INTERLOCK_CYCLES - 1)) begin
                  lx_r <= lx_target_r ? LX_UTIL : LX_DRIVE;
               end else begin
                  gap_cnt_r <= gap_cnt_r + 32'h1;
               end
            end
            default: begin
               lx_r <= LX_GAP;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // axi4-lite write path: address and data in either order
   wire aw_hs   = s_axi_awvalid_in && s_axi_awready_out;
   wire w_hs    = s_axi_wvalid_in && s_axi_wready_out;
   wire have_a  = wr_pend_r || aw_hs;
   wire have_d  = wd_pend_r || w_hs;
   wire [7:0]  wa  = aw_hs ? s_axi_awaddr_in : waddr_r;
   wire [31:0] wd  = w_hs ? s_axi_wdata_in : wdata_r;
   wire [3:0]  ws  = w_hs ? s_axi_wstrb_in : wstrb_r;
   wire        do_wr = have_a && have_d && !s_axi_bvalid_out;
   wire        wr_ok = (wa[7:2] <= aocs_pkg::OFS_APP_MODE[7:2]);

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         s_axi_awready_out <= 1'b1;
         s_axi_wready_out  <= 1'b1;
         s_axi_bvalid_out  <= 1'b0;
         s_axi_bresp_out   <= 2'h0;
         wr_pend_r <= 1'b0;
         wd_pend_r <= 1'b0;
         waddr_r   <= 8'h0;
         wdata_r   <= 32'h0;
         wstrb_r   <= 4'h0;
      end else begin
         if (aw_hs) begin
            waddr_r           <= s_axi_awaddr_in;
            s_axi_awready_out <= 1'b0;
         end
         if (w_hs) begin
            wdata_r          <= s_axi_wdata_in;
            wstrb_r          <= s_axi_wstrb_in;
            s_axi_wready_out <= 1'b0;
         end
         wr_pend_r <= have_a && !do_wr;
         wd_pend_r <= have_d && !do_wr;
         if (do_wr) begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out  <= wr_ok ? 2'h0 : 2'h2;   // slverr when unmapped or read-only
         end else if (s_axi_bvalid_out && s_axi_bready_in) begin
            s_axi_bvalid_out  <= 1'b0;
            s_axi_awready_out <= 1'b1;
            s_axi_wready_out  <= 1'b1;
         end
      end
   end

   // register storage
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < 4; i++) begin
            sel_r[i] <= aocs_pkg::RST_SEL;
         end
         fdt_freq_r               <= aocs_pkg::RST_WORD;
         fdt_bw_r                 <= aocs_pkg::RST_WORD;
         load_warning_level       <= aocs_pkg::RST_WORD;
         load_warning_time        <= aocs_pkg::RST_WORD;
         application_mode_setting <= aocs_pkg::RST_APP_MODE;
      end else if (do_wr) begin
         case (wa[7:2])
            aocs_pkg::OFS_SEL0[7:2]:     if (ws[0]) sel_r[0] <= wd[4:0];
            aocs_pkg::OFS_SEL1[7:2]:     if (ws[0]) sel_r[1] <= wd[4:0];
            aocs_pkg::OFS_SEL2[7:2]:     if (ws[0]) sel_r[2] <= wd[4:0];
            aocs_pkg::OFS_SEL3[7:2]:     if (ws[0]) sel_r[3] <= wd[4:0];
            aocs_pkg::OFS_FDT_FREQ[7:2]: fdt_freq_r <= merge16(fdt_freq_r, wd, ws);
            aocs_pkg::OFS_FDT_BW[7:2]:   fdt_bw_r <= merge16(fdt_bw_r, wd, ws);
            aocs_pkg::OFS_LW_LEVEL[7:2]: load_warning_level <= merge16(load_warning_level, wd, ws);
            aocs_pkg::OFS_LW_TIME[7:2]:  load_warning_time <= merge16(load_warning_time, wd, ws);
            aocs_pkg::OFS_APP_MODE[7:2]: if (ws[0]) application_mode_setting <= wd[3:0];
            default: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // axi4-lite read path, one cycle answer
   wire [4:0] sel_rd = s_axi_araddr_in[3:2] == 2'h0 ? sel_r[0] :
                       s_axi_araddr_in[3:2] == 2'h1 ? sel_r[1] :
                       s_axi_araddr_in[3:2] == 2'h2 ? sel_r[2] : sel_r[3];
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0;
      case (s_axi_araddr_in[7:2])
         aocs_pkg::OFS_SEL0[7:2], aocs_pkg::OFS_SEL1[7:2],
         aocs_pkg::OFS_SEL2[7:2], aocs_pkg::OFS_SEL3[7:2]: rd_mux = {27'h0, sel_rd};
         aocs_pkg::OFS_FDT_FREQ[7:2]: rd_mux = {16'h0, fdt_freq_r};
         aocs_pkg::OFS_FDT_BW[7:2]:   rd_mux = {16'h0, fdt_bw_r};
         aocs_pkg::OFS_LW_LEVEL[7:2]: rd_mux = {16'h0, load_warning_level};
         aocs_pkg::OFS_LW_TIME[7:2]:  rd_mux = {16'h0, load_warning_time};
         aocs_pkg::OFS_APP_MODE[7:2]: rd_mux = {28'h0, application_mode_setting};
         aocs_pkg::OFS_STATUS[7:2]: begin
            rd_mux[aocs_pkg::ST_CONTACT_LSB +: 4] = aux_contact_out;
            rd_mux[aocs_pkg::ST_TRIP_BIT]         = overload_trip_out;
            rd_mux[aocs_pkg::ST_OVL_BIT]          = ovl_warn_r;
         end
         default: rd_mux = 32'h0;
      endcase
   end
   wire rd_ok = (s_axi_araddr_in[7:2] <= aocs_pkg::OFS_STATUS[7:2]);

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         s_axi_arready_out <= 1'b1;
         s_axi_rvalid_out  <= 1'b0;
         s_axi_rdata_out   <= 32'h0;
         s_axi_rresp_out   <= 2'h0;
      end else if (s_axi_arvalid_in && s_axi_arready_out) begin
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out  <= 1'b1;
         s_axi_rdata_out   <= rd_mux;
         s_axi_rresp_out   <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid_out && s_axi_rready_in) begin
         s_axi_rvalid_out  <= 1'b0;
         s_axi_arready_out <= 1'b1;
      end
   end

endmodule // aocs_top

/* tb/aocs_properties.sv */
// checker: port-level properties of the aux contact selector
`timescale 1ns/1ps
module aocs_properties #(parameter longint OVL_WARN_CYCLES = 20, parameter longint OVL_TRIP_CYCLES = 20) (
   input wire logic clk_in, rst_n_in, s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out,
   input wire logic s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out, s_axi_rvalid_out,
   input wire logic s_axi_rready_in, overload_trip_out, output_cutoff_out,
   input wire logic [31:0] s_axi_rdata_out,
   input wire logic [1:0] s_axi_rresp_out,
   input wire logic [3:0] aux_contact_out,
   input wire aocs_pkg::aocs_meas_type meas_in
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // consecutive over-current samples
   logic [63:0] over_run_r;
   wire logic over_w = {16'h0, meas_in.out_current} * 32'd100 > {16'h0, meas_in.rated_current} * 32'd110;
   always_ff @(posedge clk_in) over_run_r <= (over_w && rst_n_in) ? over_run_r + 64'h1 : 64'h0;
   ////////////////////////////////////////////////////////////////
   trip_cut_a: assert property (overload_trip_out == output_cutoff_out) else $error("cutoff differs");
   trip_hold_a: assert property (overload_trip_out |=> overload_trip_out) else $error("trip dropped");
   trip_delay_a: assert property ($rose(overload_trip_out) |->
      over_run_r == OVL_WARN_CYCLES + OVL_TRIP_CYCLES + 1) else $error("trip at wrong time");
   reset_clear_a: assert property ($rose(rst_n_in) |-> aux_contact_out == 4'h0 && !overload_trip_out)
      else $error("outputs not cleared");
   wr_answer_a: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
      |=> s_axi_bvalid_out) else $error("no write response");
   b_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out) else $error("bvalid dropped");
   r_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
      else $error("read data unstable");
   rd_answer_a: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out) else $error("no read data");
   busy_refuse_a: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
      else $error("write taken while busy");
   err_zero_a: assert property (s_axi_rvalid_out && s_axi_rresp_out == 2'h2 |-> s_axi_rdata_out == 32'h0)
      else $error("error read not zero");
   cover property ($rose(overload_trip_out));
   cover property (s_axi_rvalid_out && s_axi_rresp_out == 2'h2);
   cover property ($fell(aux_contact_out[0]) ##[1:20] $rose(aux_contact_out[3]));
endmodule // aocs_properties
bind aocs_top aocs_properties #(.OVL_WARN_CYCLES(OVL_WARN_CYCLES), .OVL_TRIP_CYCLES(OVL_TRIP_CYCLES))
   aocs_properties_inst (.clk_in, .rst_n_in, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in,
   .s_axi_wready_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_arvalid_in, .s_axi_arready_out,
   .s_axi_rvalid_out, .s_axi_rready_in, .overload_trip_out, .output_cutoff_out, .s_axi_rdata_out,
   .s_axi_rresp_out, .aux_contact_out, .meas_in);

/* tb/aocs_relay_bank.sv */
// partner: relay bank behind the four aux contacts
`timescale 1ns/1ps
module aocs_relay_bank #(parameter int DRV_BIT = 0, parameter int UTL_BIT = 3) (
   input  wire logic       clk_in,
   input  wire logic [3:0] coil_in,
   output int              clash_out,
   output logic [3:0]      closed_out
);
   initial clash_out = 0;
   // contacts follow coils one edge later; both line contactors at once would short the lines
   always @(posedge clk_in) begin
      closed_out <= coil_in;
      if (coil_in[DRV_BIT] && coil_in[UTL_BIT]) clash_out <= clash_out + 1;
   end
endmodule // aocs_relay_bank

/* tb/aocs_top_tb.sv */
// testbench: register access, condition modes, timers and line exchange
`timescale 1ns/1ps
module aocs_top_tb;
   logic clk_in = 0, rst_n_in = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
   logic [7:0]  aw = 0, ar = 0;
   logic [31:0] wd = 0, dat, rd;
   logic [1:0]  rsp, bres, rres;
   logic        awr, wrdy, bv, arr, rv, trip, cut;
   logic [3:0]  cx, rly;
   aocs_pkg::aocs_meas_type  m = {48'h0, 16'h03e8};
   aocs_pkg::aocs_flags_type f = '0;
   int failures = 0, checked = 0, clash, gap;
   // code, ref, out, accel/decel, expected
   logic [47:0] ft [12] = '{48'h01_01f4_0226_0_1, 48'h01_01f4_0227_0_0, 48'h02_03e8_041a_0_1,
      48'h02_01f4_01f4_0_0, 48'h03_0000_03b6_0_1, 48'h03_0000_03b5_0_0, 48'h04_0000_03e7_2_0,
      48'h04_0000_03e8_2_1, 48'h04_0000_03b7_1_1, 48'h04_0000_03b6_1_0, 48'h05_0000_03b6_1_1,
      48'h05_0000_03e8_2_0};
   // code, flags, expected set, expected clear
   logic [27:0] st [12] = '{28'h08_100_1_0, 28'h09_080_1_0, 28'h0a_040_1_0, 28'h0b_020_1_0, 28'h0c_010_1_0,
      28'h0d_008_1_0, 28'h0e_008_0_1, 28'h0f_008_1_0, 28'h0f_408_0_0, 28'h12_004_1_0, 28'h13_002_1_0,
      28'h00_7fe_0_0};
   always #5 clk_in = ~clk_in;
   aocs_top #(.OVL_WARN_CYCLES(20), .OVL_TRIP_CYCLES(20), .INTERLOCK_CYCLES(10), .LW_UNIT_CYCLES(2)) aocs_top_inst (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .s_axi_awaddr_in(aw), .s_axi_awvalid_in(awv),
      .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv),
      .s_axi_wready_out(wrdy), .s_axi_bresp_out(bres), .s_axi_bvalid_out(bv), .s_axi_bready_in(br),
      .s_axi_araddr_in(ar), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rd),
      .s_axi_rresp_out(rres), .s_axi_rvalid_out(rv), .s_axi_rready_in(rr), .meas_in(m), .flags_in(f),
      .aux_contact_out(cx), .overload_trip_out(trip), .output_cutoff_out(cut));
   aocs_relay_bank aocs_relay_bank_inst (.clk_in(clk_in), .coil_in(cx), .clash_out(clash), .closed_out(rly));
   ////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   // write: address and data offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      aw <= a; wd <= d; awv <= 1; wv <= 1; br <= 1;
      do begin
         @(posedge clk_in);
         if (awr) awv <= 0;
         if (wrdy) wv <= 0;
      end while (!bv);
      rsp = bres; br <= 0;
   endtask
   task automatic rdr(input logic [7:0] a);
      @(posedge clk_in);
      ar <= a; arv <= 1; rr <= 1;
      do begin
         @(posedge clk_in);
         if (arr) arv <= 0;
      end while (!rv);
      dat = rd; rsp = rres; rr <= 0;
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #100us failures++;
      summarize;
   end
   ////////////////////////////////////////////////////////////////
   initial begin
      cyc(5); rst_n_in <= 1;
      rdr(8'h24); chk(dat, 0); chk(rsp, 0);
      rdr(8'h28); chk(rsp, 2); chk(dat, 0);
      wr(8'h28, 5); chk(rsp, 2);
      wr(8'h10, 16'h03e8); wr(8'h14, 16'h0064); rdr(8'h14); chk(dat, 16'h0064);
      $display("registers done");
      foreach (ft[i]) begin
         wr(8'h00, ft[i][47:40]);
         m.ref_freq <= ft[i][39:24]; m.out_freq <= ft[i][23:8]; {f.accel, f.decel} <= ft[i][5:4];
         cyc(3); chk(cx[0], ft[i][0]);
      end
      foreach (st[i]) begin
         wr(8'(4 * (i % 4)), st[i][27:20]);
         f <= st[i][18:8]; cyc(3); chk(cx[i % 4], st[i][4]);
         f <= '0; cyc(3); chk(cx[i % 4], st[i][0]);
      end
      $display("condition modes done");
      wr(8'h04, 6); wr(8'h18, 16'h0200); wr(8'h1c, 2);
      m.out_current <= 16'h0200; cyc(2); chk(cx[1], 0); cyc(20); chk(cx[1], 1);
      m.out_current <= 16'h01ff; cyc(3); chk(cx[1], 0);
      wr(8'h08, 7); m.out_current <= 16'd1100; cyc(60); chk(cx[2], 0); chk(trip, 0);
      m.out_current <= 16'd1101; cyc(10); chk(cx[2], 0); cyc(20); chk(cx[2], 1); chk(trip, 0);
      cyc(20); chk(trip, 1); chk(cut, 1); m.out_current <= 0; cyc(3); chk(trip, 1);
      rdr(8'h24); chk(dat[8], 1);
      $display("timers done");
      wr(8'h00, 16); wr(8'h0c, 17); cyc(3); chk({cx[3], cx[0]}, 2'b01);
      for (int k = 0; k < 2; k++) begin
         f.exchange <= (k == 0); gap = 0;
         repeat (30) @(negedge clk_in) gap += (cx[0] | cx[3]) ? 0 : 1;
         chk(gap >= 10 && gap <= 12, 1); chk({cx[3], cx[0]}, k ? 2'b01 : 2'b10);
         @(posedge clk_in);
      end
      chk(clash, 0); chk(rly, cx);
      wr(8'h20, 1); cyc(3); chk(cx, 0);
      // mid-run reset: latched trip and contacts must clear
      rst_n_in <= 0; cyc(2); rst_n_in <= 1; cyc(2);
      chk(trip, 0); chk(cut, 0); chk(cx, 0);
      $display("exchange done");
      summarize;
   end
endmodule // aocs_top_tb
